/* ttl_limit_unit.sv */
// torque and target limit unit: clamps the torque command to the active
// forward or reverse limit and checks target positions against software limits.
// assumes synchronous inputs, one 40 MHz clock and a classic wishbone master.
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ttl_limit_unit #(
  parameter int TQ_W = 12, // signed torque command width, at least 11
  parameter logic [9:0] MOTOR_MAX_RST = 10'h320 // motor peak torque, 1 % units
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // torque path
  input wire logic signed [TQ_W-1:0] torque_cmd_i,
  output logic signed [TQ_W-1:0] torque_o,
  // external limit inputs and limit detect output, active low
  input wire logic fwd_ext_limit_in_n,
  input wire logic rev_ext_limit_in_n,
  output logic limit_detect_out_n_o,
  // target positions
  input wire ttl_pkg::ttl_tgt_t tgt_i,
  input wire ttl_pkg::ttl_org_t org_i,
  output logic tgt_valid_o,
  output logic [31:0] tgt_pos_o,
  output logic decel_stop_o
);
  import ttl_pkg::*;

  // complete state of the unit
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [15:0] soft_limit_select_param;
    logic [9:0] fwd_internal_torque_cap;
    logic [9:0] rev_internal_torque_cap;
    logic [9:0] fwd_internal_force_cap;
    logic [9:0] rev_internal_force_cap;
    logic [9:0] fwd_external_cap;
    logic [9:0] rev_external_cap;
    logic [9:0] motor_max;
    logic [31:0] fwd_soft_limit;
    logic [31:0] rev_soft_limit;
    logic linear;
    ttl_ctrl_t ctrl;
    logic fwd_ext_option_field;
    logic rev_ext_option_field;
    logic [9:0] fwd_limit_cmd;
    logic [9:0] rev_limit_cmd;
    logic fwd_cmd_v;
    logic rev_cmd_v;
    logic [7:0] div;
    logic signed [TQ_W-1:0] torque;
    logic fwd_lim;
    logic rev_lim;
    logic clt_n;
    logic origin;
    logic stop_sticky;
    logic tgt_valid;
    logic [31:0] tgt_pos;
    logic decel;
  } ttl_state_t;

  ttl_state_t st_r; // registered state
  ttl_state_t st_nxt; // next state

  // smaller of two limits
  function automatic logic [9:0] lim_min(input logic [9:0] a, input logic [9:0] b);
    lim_min = (a < b) ? a : b;
  endfunction : lim_min

  // byte-lane merge of a write into a word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
    begin
      lane_merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : lane_merge

  // saturate a written cap to the 800 % ceiling
  function automatic logic [9:0] cap_sat(input logic [31:0] v);
    cap_sat = (v[15:0] > {6'h00, CAP_MAX}) ? CAP_MAX : v[9:0];
  endfunction : cap_sat

  logic ctrl_en; // one-cycle control cycle strobe
  logic fwd_ext_on; // forward external limit applied
  logic rev_ext_on; // reverse external limit applied
  logic net_ok; // network limit commands allowed in this mode
  logic [9:0] fwd_base; // forward limit without network command
  logic [9:0] rev_base; // reverse limit without network command
  logic [9:0] fwd_eff; // effective forward limit
  logic [9:0] rev_eff; // effective reverse limit
  logic cmd_neg; // torque command is negative
  logic [TQ_W-1:0] cmd_mag; // torque command magnitude
  logic [TQ_W-1:0] lim_sel; // limit chosen by the command sign
  logic check_on; // reference check enabled
  logic tgt_checked; // target is of a checked kind
  logic over_fwd; // target beyond forward soft limit
  logic over_rev; // target beyond reverse soft limit
  logic bus_req; // new wishbone access this cycle

  // limit selection, recomputed combinationally each cycle
  always_comb
  begin
    // pins are active low; option fields add the command source
    fwd_ext_on = !fwd_ext_limit_in_n ||
                 (st_r.fwd_ext_option_field && st_r.ctrl != TTL_TORQUE);
    rev_ext_on = !rev_ext_limit_in_n ||
                 (st_r.rev_ext_option_field && st_r.ctrl != TTL_TORQUE);
    // linear motors use the force caps, rotary the torque caps
    fwd_base = st_r.linear ? st_r.fwd_internal_force_cap : st_r.fwd_internal_torque_cap;
    rev_base = st_r.linear ? st_r.rev_internal_force_cap : st_r.rev_internal_torque_cap;
    // never beyond what the motor can produce
    fwd_base = lim_min(fwd_base, st_r.motor_max);
    rev_base = lim_min(rev_base, st_r.motor_max);
    // external caps from the pins apply in every control mode, from the option fields in all but torque control
    fwd_base = fwd_ext_on ? lim_min(fwd_base, st_r.fwd_external_cap) : fwd_base;
    rev_base = rev_ext_on ? lim_min(rev_base, st_r.rev_external_cap) : rev_base;
    // network commands only in speed and position control
    net_ok = (st_r.ctrl == TTL_SPEED) || (st_r.ctrl == TTL_POSITION);
    fwd_eff = (net_ok && st_r.fwd_cmd_v) ?
              lim_min(fwd_base, st_r.fwd_limit_cmd) : fwd_base;
    rev_eff = (net_ok && st_r.rev_cmd_v) ?
              lim_min(rev_base, st_r.rev_limit_cmd) : rev_base;
    // sign selects the limit set
    cmd_neg = torque_cmd_i[TQ_W-1];
    cmd_mag = cmd_neg ? TQ_W'(-torque_cmd_i) : TQ_W'(torque_cmd_i);
    lim_sel = cmd_neg ? {{(TQ_W-10){1'b0}}, rev_eff} : {{(TQ_W-10){1'b0}}, fwd_eff};
    // reference check conditions
    check_on = st_r.soft_limit_select_param[SEL_REF_LO +: 4] == REF_CHECK_ON;
    tgt_checked = tgt_i.valid && (tgt_i.kind == TTL_CMD_POSITIONING ||
                                  tgt_i.kind == TTL_CMD_INTERPOLATION);
    over_fwd = check_on && tgt_checked && st_r.origin &&
               !st_r.soft_limit_select_param[SEL_FWD_OFF] &&
               ($signed(tgt_i.pos) > $signed(st_r.fwd_soft_limit));
    over_rev = check_on && tgt_checked && st_r.origin &&
               !st_r.soft_limit_select_param[SEL_REV_OFF] &&
               ($signed(tgt_i.pos) < $signed(st_r.rev_soft_limit));
    ctrl_en = st_r.div == 8'(CTRL_CYC - 1);
    bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
  end

  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = bus_req;
    st_nxt.decel = 1'b0;
    st_nxt.tgt_valid = tgt_i.valid;
    // control cycle divider
    st_nxt.div = ctrl_en ? 8'h00 : st_r.div + 8'h01;
    // clamp the command magnitude once per control cycle
    if (ctrl_en)
    begin
      st_nxt.torque = torque_cmd_i;
      if (cmd_mag > lim_sel)
      begin
        st_nxt.torque = cmd_neg ? TQ_W'(-$signed(lim_sel)) : $signed(lim_sel);
      end
      st_nxt.fwd_lim = !cmd_neg && (cmd_mag > lim_sel);
      st_nxt.rev_lim = cmd_neg && (cmd_mag > lim_sel);
      st_nxt.clt_n = !(cmd_mag > lim_sel);
    end
    // origin defined by return or flagged position set; an unflagged set clears it
    st_nxt.origin = org_i.origin_return_cmd || (org_i.pos_set && org_i.origin_valid_flag) ||
                    (st_r.origin && !org_i.pos_set);
    // target pass-through or stop at the soft limit
    st_nxt.tgt_pos = tgt_i.pos;
    if (over_fwd)
    begin
      st_nxt.tgt_pos = st_r.fwd_soft_limit;
      st_nxt.decel = 1'b1;
    end
    else if (over_rev)
    begin
      st_nxt.tgt_pos = st_r.rev_soft_limit;
      st_nxt.decel = 1'b1;
    end
    // register read, answered with the ack
    unique case (wb_adr_i)
      OFS_SOFT_SEL: st_nxt.rdat = {16'h0000, st_r.soft_limit_select_param};
      OFS_FWD_INT_TQ: st_nxt.rdat = {22'h000000, st_r.fwd_internal_torque_cap};
      OFS_REV_INT_TQ: st_nxt.rdat = {22'h000000, st_r.rev_internal_torque_cap};
      OFS_FWD_INT_FRC: st_nxt.rdat = {22'h000000, st_r.fwd_internal_force_cap};
      OFS_REV_INT_FRC: st_nxt.rdat = {22'h000000, st_r.rev_internal_force_cap};
      OFS_FWD_EXT: st_nxt.rdat = {22'h000000, st_r.fwd_external_cap};
      OFS_REV_EXT: st_nxt.rdat = {22'h000000, st_r.rev_external_cap};
      OFS_FWD_SOFT: st_nxt.rdat = st_r.fwd_soft_limit;
      OFS_REV_SOFT: st_nxt.rdat = st_r.rev_soft_limit;
      OFS_MODE: st_nxt.rdat = {27'h0000000, st_r.rev_ext_option_field,
                               st_r.fwd_ext_option_field, st_r.ctrl, st_r.linear};
      OFS_LIM_CMD: st_nxt.rdat = {st_r.rev_cmd_v, st_r.fwd_cmd_v, 4'h0, st_r.rev_limit_cmd,
                                  6'h00, st_r.fwd_limit_cmd};
      OFS_MOTOR_MAX: st_nxt.rdat = {22'h000000, st_r.motor_max};
      OFS_STATUS: st_nxt.rdat = {26'h0000000, rev_ext_on, fwd_ext_on, st_r.stop_sticky,
                                 st_r.origin, st_r.rev_lim, st_r.fwd_lim};
      default: st_nxt.rdat = 32'h00000000;
    endcase
    // register write, taken with the ack
    if (bus_req && wb_we_i)
    begin
      unique case (wb_adr_i)
        OFS_SOFT_SEL: st_nxt.soft_limit_select_param = 16'(lane_merge(
          {16'h0000, st_r.soft_limit_select_param}, wb_dat_i, wb_sel_i));
        OFS_FWD_INT_TQ: st_nxt.fwd_internal_torque_cap = cap_sat(lane_merge(
          {22'h000000, st_r.fwd_internal_torque_cap}, wb_dat_i, wb_sel_i));
        OFS_REV_INT_TQ: st_nxt.rev_internal_torque_cap = cap_sat(lane_merge(
          {22'h000000, st_r.rev_internal_torque_cap}, wb_dat_i, wb_sel_i));
        OFS_FWD_INT_FRC: st_nxt.fwd_internal_force_cap = cap_sat(lane_merge(
          {22'h000000, st_r.fwd_internal_force_cap}, wb_dat_i, wb_sel_i));
        OFS_REV_INT_FRC: st_nxt.rev_internal_force_cap = cap_sat(lane_merge(
          {22'h000000, st_r.rev_internal_force_cap}, wb_dat_i, wb_sel_i));
        OFS_FWD_EXT: st_nxt.fwd_external_cap = cap_sat(lane_merge(
          {22'h000000, st_r.fwd_external_cap}, wb_dat_i, wb_sel_i));
        OFS_REV_EXT: st_nxt.rev_external_cap = cap_sat(lane_merge(
          {22'h000000, st_r.rev_external_cap}, wb_dat_i, wb_sel_i));
        OFS_FWD_SOFT: st_nxt.fwd_soft_limit = lane_merge(st_r.fwd_soft_limit, wb_dat_i, wb_sel_i);
        OFS_REV_SOFT: st_nxt.rev_soft_limit = lane_merge(st_r.rev_soft_limit, wb_dat_i, wb_sel_i);
        OFS_MODE:
        begin
          if (wb_sel_i[0])
          begin
            st_nxt.linear = wb_dat_i[MODE_LINEAR];
            // illegal mode code falls back to speed control
            st_nxt.ctrl = (wb_dat_i[MODE_CTRL_LO +: 2] == 2'b11) ? TTL_SPEED :
                          ttl_ctrl_t'(wb_dat_i[MODE_CTRL_LO +: 2]);
            st_nxt.fwd_ext_option_field = wb_dat_i[MODE_FWD_OPT];
            st_nxt.rev_ext_option_field = wb_dat_i[MODE_REV_OPT];
          end
        end
        OFS_LIM_CMD:
        begin
          // mask each field so valid bits and spare bits never reach the saturation
          st_nxt.fwd_limit_cmd = cap_sat(lane_merge({22'h000000, st_r.fwd_limit_cmd},
            wb_dat_i & 32'h000003ff, wb_sel_i));
          st_nxt.rev_limit_cmd = cap_sat(lane_merge({22'h000000, st_r.rev_limit_cmd},
            (wb_dat_i >> CMD_REV_LO) & 32'h000003ff, wb_sel_i >> 2));
          if (wb_sel_i[3])
          begin
            st_nxt.fwd_cmd_v = wb_dat_i[CMD_FWD_V];
            st_nxt.rev_cmd_v = wb_dat_i[CMD_REV_V];
          end
        end
        OFS_MOTOR_MAX: st_nxt.motor_max = cap_sat(lane_merge(
          {22'h000000, st_r.motor_max}, wb_dat_i, wb_sel_i));
        OFS_STATUS: st_nxt.stop_sticky = st_r.stop_sticky &&
          !(wb_sel_i[0] && wb_dat_i[ST_STOP]);
        default: ; // unmapped writes are ignored
      endcase
    end
    // a stop event wins over a clear in the same cycle
    st_nxt.stop_sticky = st_nxt.stop_sticky || over_fwd || over_rev;
  end

  // state register with synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.soft_limit_select_param <= RST_SOFT_SEL;
      st_r.fwd_internal_torque_cap <= RST_TQ_CAP;
      st_r.rev_internal_torque_cap <= RST_TQ_CAP;
      st_r.fwd_internal_force_cap <= RST_FRC_CAP;
      st_r.rev_internal_force_cap <= RST_FRC_CAP;
      st_r.fwd_external_cap <= RST_EXT_CAP;
      st_r.rev_external_cap <= RST_EXT_CAP;
      st_r.motor_max <= MOTOR_MAX_RST;
      st_r.fwd_soft_limit <= RST_FWD_SOFT;
      st_r.rev_soft_limit <= RST_REV_SOFT;
      st_r.ctrl <= TTL_SPEED;
      st_r.clt_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign torque_o = st_r.torque;
  assign limit_detect_out_n_o = st_r.clt_n;
  assign tgt_valid_o = st_r.tgt_valid;
  assign tgt_pos_o = st_r.tgt_pos;
  assign decel_stop_o = st_r.decel;

  // checks
  localparam int CYC_BOUND = CTRL_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_over_fwd;
    over_fwd;
  endsequence
  sequence s_stop_at_fwd;
    decel_stop_o && tgt_pos_o == $past(st_r.fwd_soft_limit) && tgt_valid_o;
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (bus_req |=> wb_ack_o)
    else $error("access not answered next cycle");
  a_ctrl_period: assert property (ctrl_en |-> ##[1:CYC_BOUND] ctrl_en)
    else $error("control cycle strobe missing");
  a_fwd_clamp: assert property (ctrl_en && !cmd_neg |=>
    torque_o <= $signed({1'b0, $past(fwd_eff)}) && torque_o >= 0)
    else $error("forward torque above effective limit");
  a_rev_clamp: assert property (ctrl_en && cmd_neg |=>
    -torque_o <= $signed({1'b0, $past(rev_eff)}) && torque_o <= 0)
    else $error("reverse torque above effective limit");
  a_ext_fwd_cap: assert property (!fwd_ext_limit_in_n |->
    fwd_eff <= st_r.fwd_external_cap && fwd_eff <= st_r.motor_max)
    else $error("forward external cap not applied");
  a_torque_no_net: assert property (st_r.ctrl == TTL_TORQUE |->
    fwd_eff == fwd_base && rev_eff == rev_base)
    else $error("network limit used in torque control");
  a_clt_level: assert property (ctrl_en |=>
    limit_detect_out_n_o == !($past(cmd_mag) > $past(lim_sel)))
    else $error("limit detect output wrong");
  a_soft_stop: assert property (s_over_fwd |=> s_stop_at_fwd)
    else $error("no stop at forward soft limit");
  a_check_gate: assert property (!check_on || !st_r.origin |=> !decel_stop_o)
    else $error("stop without check enabled or origin");
  a_cap_range: assert property (st_r.fwd_internal_torque_cap <= CAP_MAX &&
    st_r.fwd_external_cap <= CAP_MAX && st_r.rev_internal_force_cap <= CAP_MAX)
    else $error("cap above 800 percent");

endmodule : ttl_limit_unit

`default_nettype wire

/* ttl_pkg.sv */
// package for the torque and target limit unit: register map, field layout,
// reset values, mode encodings, timing constants and the state carriers.
// assumes a 40 MHz control clock and a 32-bit classic wishbone register bus.
package ttl_pkg;

  // clock and control cycle timing
  localparam int CLK_PERIOD_NS = 25; // control clock period
  localparam int CTRL_PERIOD_NS = 400; // torque clamp update period
  localparam int CTRL_CYC = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_SOFT_SEL = 8'h00;
  localparam logic [7:0] OFS_FWD_INT_TQ = 8'h04;
  localparam logic [7:0] OFS_REV_INT_TQ = 8'h08;
  localparam logic [7:0] OFS_FWD_INT_FRC = 8'h0c;
  localparam logic [7:0] OFS_REV_INT_FRC = 8'h10;
  localparam logic [7:0] OFS_FWD_EXT = 8'h14;
  localparam logic [7:0] OFS_REV_EXT = 8'h18;
  localparam logic [7:0] OFS_FWD_SOFT = 8'h1c;
  localparam logic [7:0] OFS_REV_SOFT = 8'h20;
  localparam logic [7:0] OFS_MODE = 8'h24;
  localparam logic [7:0] OFS_LIM_CMD = 8'h28;
  localparam logic [7:0] OFS_MOTOR_MAX = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;

  // field positions
  localparam int SEL_REF_LO = 8; // digit that turns the reference check on
  localparam int SEL_FWD_OFF = 0; // forward software limit disable bit
  localparam int SEL_REV_OFF = 1; // reverse software limit disable bit
  localparam int MODE_LINEAR = 0;
  localparam int MODE_CTRL_LO = 1;
  localparam int MODE_FWD_OPT = 3;
  localparam int MODE_REV_OPT = 4;
  localparam int CMD_REV_LO = 16;
  localparam int CMD_FWD_V = 30;
  localparam int CMD_REV_V = 31;
  localparam int ST_STOP = 3; // sticky deceleration stop flag, write 1 to clear

  // limit values in 1 % of rated torque or force
  localparam logic [9:0] CAP_MAX = 10'h320; // 800 %
  localparam logic [9:0] RST_TQ_CAP = 10'h320; // 800 %
  localparam logic [9:0] RST_FRC_CAP = 10'h01e; // 30 %
  localparam logic [9:0] RST_EXT_CAP = 10'h064; // 100 %
  localparam logic [15:0] RST_SOFT_SEL = 16'h0003;
  localparam logic [31:0] RST_FWD_SOFT = 32'h3fffffff;
  localparam logic [31:0] RST_REV_SOFT = 32'hc0000001;
  localparam logic [3:0] REF_CHECK_ON = 4'h1;

  // control method
  typedef enum logic [1:0] {
    TTL_SPEED = 2'b00,
    TTL_POSITION = 2'b01,
    TTL_TORQUE = 2'b10
  } ttl_ctrl_t;

  // command kind that arrives with a target position
  typedef enum logic [1:0] {
    TTL_CMD_OTHER = 2'b00,
    TTL_CMD_POSITIONING = 2'b01,
    TTL_CMD_INTERPOLATION = 2'b10
  } ttl_kind_t;

  // target command from the motion command decoder
  typedef struct packed {
    logic valid;
    ttl_kind_t kind;
    logic [31:0] pos;
  } ttl_tgt_t;

  // origin definition events
  typedef struct packed {
    logic origin_return_cmd; // origin return finished
    logic pos_set; // position set command
    logic origin_valid_flag; // reference flag of the position set
  } ttl_org_t;

endpackage : ttl_pkg

/* ttl_host_model.sv */
// host side model: drives the two active-low external limit pins.
// assumes requests arrive from the bench synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ttl_host_model (
  // clock
  input wire logic clk_i,
  // requests from the test sequence
  input wire logic fwd_req_i,
  input wire logic rev_req_i,
  // limit pins toward the unit, active low
  output logic fwd_ext_limit_in_n_o,
  output logic rev_ext_limit_in_n_o
);
  // pins are allocated terminals, so they always carry a real level
  always_ff @(posedge clk_i)
  begin
    fwd_ext_limit_in_n_o <= ~fwd_req_i;
    rev_ext_limit_in_n_o <= ~rev_req_i;
  end
endmodule : ttl_host_model
`default_nettype wire

/* test_torque_and_target_limit_unit.sv */
// testbench for the torque and target limit unit over its wishbone port.
// assumes the package constants and one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_torque_and_target_limit_unit;
  import ttl_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, fq = 0, rq = 0, fn, rn; // bench drives
  logic [7:0] adr = '0;
  logic [31:0] di = '0, dq;
  logic signed [11:0] cmd = '0;
  ttl_tgt_t tgt = '0;
  ttl_org_t org = '0;
  wire logic [31:0] dout;
  wire logic ack, det_n, tv, dec;
  wire logic [31:0] tpos;
  wire logic signed [11:0] tq_o;
  int mismatches = 0, samples_checked = 0;
  // clock of 25 ns period
  always #12.5 clk_i = ~clk_i;
  ttl_limit_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(di), .wb_dat_o(dout),
    .wb_ack_o(ack), .torque_cmd_i(cmd), .torque_o(tq_o), .fwd_ext_limit_in_n(fn),
    .rev_ext_limit_in_n(rn), .limit_detect_out_n_o(det_n), .tgt_i(tgt), .org_i(org),
    .tgt_valid_o(tv), .tgt_pos_o(tpos), .decel_stop_o(dec));
  ttl_host_model host (.clk_i(clk_i), .fwd_req_i(fq), .rev_req_i(rq),
    .fwd_ext_limit_in_n_o(fn), .rev_ext_limit_in_n_o(rn));
  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // compare seen against expected
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one classic wishbone cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    di <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    dq = dout;
    cyc <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      mismatches++;
      print_verdict();
    end
  endtask : wb
  // torque command, two control cycles, then output and detect flag
  task automatic tq(input int c, input int e, input logic dn);
    @(posedge clk_i);
    cmd <= 12'(c);
    repeat (34) @(posedge clk_i);
    #1;
    chk("torque", 32'(tq_o), 32'(e));
    chk("detect", 32'(det_n), 32'(dn));
  endtask : tq
  // one target pulse, outputs looked at one cycle later
  task automatic tg(input ttl_kind_t k, input int p, input int e, input logic d);
    @(posedge clk_i);
    tgt <= '{valid: 1'b1, kind: k, pos: 32'(p)};
    @(posedge clk_i);
    tgt <= '0;
    #1;
    chk("tgt_valid", 32'(tv), 32'h1);
    chk("tgt_pos", tpos, 32'(e));
    chk("decel", 32'(dec), 32'(d));
  endtask : tg
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, OFS_FWD_INT_TQ, 0); chk("fwd_tq_rst", dq, 32'h320);
    chk("det_rst", 32'(det_n), 32'h1);
    chk("tq_rst", 32'(tq_o), 32'h0);
    wb(0, OFS_REV_INT_FRC, 0); chk("rev_frc_rst", dq, 32'h1e);
    wb(0, OFS_FWD_EXT, 0); chk("fwd_ext_rst", dq, 32'h64);
    wb(0, OFS_SOFT_SEL, 0); chk("sel_rst", dq, 32'h3);
    wb(0, 8'hfc, 0); chk("unmapped", dq, 32'h0);
    wb(1, OFS_FWD_INT_TQ, 32'h384); wb(0, OFS_FWD_INT_TQ, 0);
    chk("cap_sat", dq, 32'h320);
    wb(1, OFS_FWD_INT_TQ, 32'hc8);
    tq(300, 200, 1'b0);
    tq(150, 150, 1'b1);
    fq <= 1'b1;
    tq(300, 100, 1'b0);
    wb(1, OFS_MODE, 32'h4);
    tq(300, 100, 1'b0);
    wb(1, OFS_LIM_CMD, 32'h4000_0028);
    wb(0, OFS_LIM_CMD, 0);
    chk("lim_cmd", dq, 32'h4000_0028);
    tq(300, 100, 1'b0);
    wb(1, OFS_MODE, 32'h0);
    tq(300, 40, 1'b0);
    wb(1, OFS_LIM_CMD, 32'h0);
    fq <= 1'b0;
    rq <= 1'b1;
    tq(-300, -100, 1'b0);
    rq <= 1'b0;
    tq(-300, -300, 1'b1);
    wb(1, OFS_MOTOR_MAX, 32'h3c);
    tq(-300, -60, 1'b0);
    wb(1, OFS_MOTOR_MAX, 32'h320);
    wb(1, OFS_MODE, 32'h1);
    tq(300, 30, 1'b0);
    wb(1, OFS_MODE, 32'h0);
    wb(1, OFS_SOFT_SEL, 32'h100);
    wb(1, OFS_FWD_SOFT, 32'h3e8);
    wb(1, OFS_REV_SOFT, 32'hfffffc18);
    tg(TTL_CMD_POSITIONING, 2000, 2000, 1'b0);
    @(posedge clk_i);
    org <= 3'b100;
    @(posedge clk_i);
    org <= '0;
    tg(TTL_CMD_POSITIONING, 2000, 1000, 1'b1);
    tg(TTL_CMD_INTERPOLATION, -2000, -1000, 1'b1);
    tg(TTL_CMD_OTHER, 2000, 2000, 1'b0);
    // sticky stop flag, then write one to clear it
    wb(0, OFS_STATUS, 0);
    chk("status_stop", dq, 32'hd);
    wb(1, OFS_STATUS, 32'h8);
    wb(0, OFS_STATUS, 0);
    chk("status_clr", dq, 32'h5);
    // forward direction disabled, reverse still checked
    wb(1, OFS_SOFT_SEL, 32'h101);
    tg(TTL_CMD_POSITIONING, 2000, 2000, 1'b0);
    tg(TTL_CMD_INTERPOLATION, -2000, -1000, 1'b1);
    wb(1, OFS_SOFT_SEL, 32'h0);
    tg(TTL_CMD_POSITIONING, 2000, 2000, 1'b0);
    // unflagged position set takes the origin away again
    wb(1, OFS_SOFT_SEL, 32'h100);
    @(posedge clk_i);
    org <= 3'b010;
    @(posedge clk_i);
    org <= '0;
    tg(TTL_CMD_POSITIONING, 2000, 2000, 1'b0);
    // reset in mid-run restores defaults and forgets the origin
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, OFS_STATUS, 0);
    chk("status_rst", dq, 32'h0);
    chk("det_rst2", 32'(det_n), 32'h1);
    wb(0, OFS_FWD_INT_TQ, 0);
    chk("fwd_tq_rst2", dq, 32'h320);
    print_verdict();
  end
endmodule : test_torque_and_target_limit_unit
`default_nettype wire
